// ==== rtl/ums_defines.vh ====
// Constants for the serial mode/status block with infrared codec
`ifndef UMS_DEFINES_VH
`define UMS_DEFINES_VH
`define UMS_OFF_MODE 3'h0
`define UMS_OFF_STAT 3'h1
`define UMS_OFF_TXD 3'h2
`define UMS_OFF_RXD 3'h3
`define UMS_OFF_BRG 3'h4
`define UMS_MODE_RST 16'h0000
`define UMS_BRG_RST 16'h0000
`define UMS_FULL16 4'hf
`define UMS_FULL4 4'h3
`define UMS_HALF16 4'h7
`define UMS_HALF4 4'h1
`define UMS_IR_PULSE 4'h3
`define UMS_FIFO_DEPTH 3'h4
`define UMS_PD_9N 2'h3
`define UMS_PD_8O 2'h2
`define UMS_PD_8E 2'h1
`define UMS_PD_8N 2'h0
`define UMS_TXI_EACH 2'h0
`define UMS_TXI_DONE 2'h1
`define UMS_TXI_EMPTY 2'h2
`define UMS_RXI_3 2'h2
`define UMS_RXI_4 2'h3
`define UMS_PINS_RTS 2'h1
`define UMS_PINS_FLOW 2'h2
`define UMS_PINS_BCLK 2'h3
`define UMS_BREAK_FRAME 16'he000
`define UMS_BREAK_LEN 4'he
`define UMS_AB_FALLS 3'h4
`endif

// ==== rtl/ums_top.v ====
// Serial transceiver mode, status, framing and infrared codec logic
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "ums_defines.vh"
module ums_top (
  input wire clk_sys,
  input wire rstn,
  input wire [2:0] bus_addr,
  input wire [15:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [15:0] bus_rdata,
  input wire cpu_idle,
  input wire cpu_sleep,
  input wire serial_in_pin,
  input wire clear_to_send_pin_n,
  output reg serial_out_pin,
  output reg serial_out_oe,
  output reg request_to_send_pin_n,
  output reg request_to_send_oe,
  output reg tx_irq,
  output reg rx_irq,
  output reg wake_irq
);
  // Mode register fields
  reg module_on_reg, stop_in_idle_reg, infrared_codec_on_reg, rts_pin_mode_reg;
  reg [1:0] pin_usage_select_reg;
  reg wake_on_start_reg, loopback_select_reg, auto_baud_on_reg;
  reg rx_polarity_invert_reg, high_baud_select_reg, stop_count_select_reg;
  reg [1:0] parity_data_select_reg;
  // Status register control fields
  reg [1:0] tx_irq_mode_reg, rx_irq_mode_reg;
  reg tx_ir_polarity_reg, tx_break_request_reg, tx_on_reg, address_detect_on_reg;
  reg overrun_error_reg;
  reg [15:0] brg_reg; // Baud divisor
  reg [15:0] brg_cnt_reg; // Baud timer
  reg bclk_reg; // Baud clock image for pin
  // Input synchronisers
  reg rx_s1_reg, rx_s2_reg, cts_s1_reg, cts_s2_reg;
  reg rx_prev_reg; // Receive line last cycle
  // Transmit FIFO and shifter
  reg [8:0] txf_reg [0:3];
  reg [1:0] txw_reg, txr_reg;
  reg [2:0] txc_reg;
  reg [15:0] tsh_reg; // Frame shifter, LSB first
  reg [3:0] tleft_reg, tsc_reg;
  reg tbusy_reg, tbrk_reg;
  // Receive FIFO {stop bad, parity bad, data9} and shifter
  reg [10:0] rxf_reg [0:3];
  reg [1:0] rxw_reg, rxr_reg;
  reg [2:0] rxc_reg;
  reg [1:0] rst_reg; // Receiver state
  reg [3:0] rsc_reg, rbit_reg;
  reg [8:0] rsh_reg;
  reg [3:0] ir_cnt_reg; // Ticks since last infrared pulse
  reg wake_fell_reg;
  reg [2:0] ab_falls_reg;
  reg [23:0] ab_cyc_reg;

  localparam RX_IDLE = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_BITS = 2'd2;
  localparam RX_STOP = 2'd3;

  // Decoded controls
  wire halt = ~module_on_reg | (stop_in_idle_reg & cpu_idle);
  wire tick = ~halt & (brg_cnt_reg == 16'h0000);
  wire ir_act = infrared_codec_on_reg & ~high_baud_select_reg;
  wire [3:0] full_n = high_baud_select_reg ? `UMS_FULL4 : `UMS_FULL16;
  wire [3:0] half_n = high_baud_select_reg ? `UMS_HALF4 : `UMS_HALF16;
  wire nine = (parity_data_select_reg == `UMS_PD_9N);
  wire [3:0] rx_nbits = (parity_data_select_reg == `UMS_PD_8N) ? 4'h8 : 4'h9;
  wire wr_mode = bus_wr & (bus_addr == `UMS_OFF_MODE);
  wire wr_stat = bus_wr & (bus_addr == `UMS_OFF_STAT);
  wire wr_txd = bus_wr & (bus_addr == `UMS_OFF_TXD);
  wire wr_brg = bus_wr & (bus_addr == `UMS_OFF_BRG);
  wire rd_rxd = bus_rd & (bus_addr == `UMS_OFF_RXD);

  // Receive line: loopback, inversion, infrared decode
  wire tx_raw = tsh_reg[0];
  wire rx_src = loopback_select_reg ? tx_raw : rx_s2_reg;
  wire rx_in = rx_src ^ rx_polarity_invert_reg;
  wire rx_line = ir_act ? (ir_cnt_reg == `UMS_FULL16) : rx_in;
  wire rx_fall = rx_prev_reg & ~rx_line;
  wire rx_rise = ~rx_prev_reg & rx_line;

  // Transmit frame assembly for the FIFO top
  wire [8:0] td = txf_reg[txr_reg];
  wire tpar = (parity_data_select_reg == `UMS_PD_8O) ? ~^td[7:0] : ^td[7:0];
  wire tb8 = nine ? td[8] : ((parity_data_select_reg == `UMS_PD_8N) ? 1'b1 : tpar);
  wire [3:0] tlen = rx_nbits + (stop_count_select_reg ? 4'h3 : 4'h2);
  wire cts_ok = (pin_usage_select_reg != `UMS_PINS_FLOW) | ~cts_s2_reg;
  wire tx_go = ~halt & tx_on_reg & ~tbusy_reg & (txc_reg != 3'h0) & cts_ok;
  wire tx_end = tick & tbusy_reg & (tsc_reg == full_n) & (tleft_reg == 4'h1);
  wire tx_push = wr_txd & (txc_reg != `UMS_FIFO_DEPTH) & tx_on_reg;

  // Receive completion and FIFO
  wire r_samp = tick & (rsc_reg == full_n);
  wire r_done = (rst_reg == RX_STOP) & r_samp;
  wire r_par_bad = (parity_data_select_reg == `UMS_PD_8E) ? ^rsh_reg :
                (parity_data_select_reg == `UMS_PD_8O) ? ~^rsh_reg : 1'b0;
  wire r_keep = ~(address_detect_on_reg & nine & ~rsh_reg[8]);
  wire r_full = (rxc_reg == `UMS_FIFO_DEPTH);
  wire r_push = r_done & r_keep & ~r_full;
  wire r_ovf = r_done & r_keep & r_full;
  wire r_pop = rd_rxd & (rxc_reg != 3'h0);
  wire [10:0] rtop = rxf_reg[rxr_reg];
  wire ovr_clr = wr_stat & ~bus_wdata[1] & overrun_error_reg & ~r_ovf;
  wire rx_hold = ovr_clr | overrun_error_reg | auto_baud_on_reg | halt;

  // Input synchronisers, two flops each
  always @(posedge clk_sys) begin
    if (!rstn) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      cts_s1_reg <= 1'b1;
      cts_s2_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_s1_reg <= serial_in_pin;
      rx_s2_reg <= rx_s1_reg;
      cts_s1_reg <= clear_to_send_pin_n;
      cts_s2_reg <= cts_s1_reg;
      rx_prev_reg <= rx_line;
    end
  end

  // Mode register, with hardware clears of wake and auto-baud
  always @(posedge clk_sys) begin
    if (!rstn) begin
      {module_on_reg, stop_in_idle_reg, infrared_codec_on_reg} <= 3'h0;
      {rts_pin_mode_reg, pin_usage_select_reg, wake_on_start_reg} <= 4'h0;
      {loopback_select_reg, auto_baud_on_reg, rx_polarity_invert_reg} <= 3'h0;
      {high_baud_select_reg, parity_data_select_reg} <= 3'h0;
      stop_count_select_reg <= 1'b0;
      wake_fell_reg <= 1'b0;
      wake_irq <= 1'b0;
    end else begin
      wake_irq <= 1'b0;
      // Wake on start edge while sleeping
      if (wake_on_start_reg & cpu_sleep & rx_fall) begin
        wake_irq <= 1'b1;
        wake_fell_reg <= 1'b1;
      end
      if (wr_mode) begin
        // Software write wins over hardware clear
        module_on_reg <= bus_wdata[15];
        stop_in_idle_reg <= bus_wdata[13];
        infrared_codec_on_reg <= bus_wdata[12];
        rts_pin_mode_reg <= bus_wdata[11];
        pin_usage_select_reg <= bus_wdata[9:8];
        wake_on_start_reg <= bus_wdata[7];
        loopback_select_reg <= bus_wdata[6];
        auto_baud_on_reg <= bus_wdata[5];
        rx_polarity_invert_reg <= bus_wdata[4];
        high_baud_select_reg <= bus_wdata[3];
        parity_data_select_reg <= bus_wdata[2:1];
        stop_count_select_reg <= bus_wdata[0];
        wake_fell_reg <= 1'b0;
      end else begin
        // Self-clear on the rising edge after the wake edge
        if (wake_fell_reg & rx_rise) begin
          wake_on_start_reg <= 1'b0;
          wake_fell_reg <= 1'b0;
        end
        if (auto_baud_on_reg & rx_fall & (ab_falls_reg == `UMS_AB_FALLS))
          auto_baud_on_reg <= 1'b0;
      end
    end
  end

  // Baud divisor, timer, auto-baud measurement and baud clock image
  always @(posedge clk_sys) begin
    if (!rstn) begin
      brg_reg <= `UMS_BRG_RST;
      brg_cnt_reg <= `UMS_BRG_RST;
      ab_falls_reg <= 3'h0;
      ab_cyc_reg <= 24'h00_0000;
      bclk_reg <= 1'b0;
    end else begin
      bclk_reg <= (brg_cnt_reg > {1'b0, brg_reg[15:1]});
      if (wr_brg) begin
        // New divisor restarts the timer
        brg_reg <= bus_wdata;
        brg_cnt_reg <= bus_wdata;
      end else if (halt | (brg_cnt_reg == 16'h0000)) begin
        brg_cnt_reg <= brg_reg;
      end else begin
        brg_cnt_reg <= brg_cnt_reg - 16'h0001;
      end
      // Sync 55h has five falling edges over eight bit times
      if (~auto_baud_on_reg | halt) begin
        ab_falls_reg <= 3'h0;
        ab_cyc_reg <= 24'h00_0000;
      end else begin
        ab_cyc_reg <= ab_cyc_reg + 24'h00_0001;
        if (rx_fall) begin
          ab_falls_reg <= ab_falls_reg + 3'h1;
          // First fall counts as cycle one, so the span is exact
          if (ab_falls_reg == 3'h0)
            ab_cyc_reg <= 24'h00_0001;
          if ((ab_falls_reg == `UMS_AB_FALLS) & ~wr_brg) begin
            if (high_baud_select_reg)
              brg_reg <= ab_cyc_reg[20:5] - 16'h0001;
            else
              brg_reg <= ab_cyc_reg[22:7] - 16'h0001;
            ab_falls_reg <= 3'h0;
          end
        end
      end
    end
  end

  // Transmit FIFO, shifter, break and status control bits
  always @(posedge clk_sys) begin
    if (!rstn) begin
      {tx_irq_mode_reg, tx_ir_polarity_reg} <= 3'h0;
      {tx_break_request_reg, tx_on_reg} <= 2'h0;
      {txw_reg, txr_reg, txc_reg} <= 7'h00;
      tsh_reg <= 16'hffff;
      {tleft_reg, tsc_reg} <= 8'h00;
      {tbusy_reg, tbrk_reg, tx_irq} <= 3'h0;
    end else begin
      tx_irq <= 1'b0;
      if (wr_stat) begin
        tx_irq_mode_reg <= {bus_wdata[15], bus_wdata[13]};
        tx_ir_polarity_reg <= bus_wdata[14];
        tx_break_request_reg <= bus_wdata[11];
        tx_on_reg <= bus_wdata[10];
      end
      if (~tx_on_reg) begin
        // Disabled transmitter: abort and flush
        {txw_reg, txr_reg, txc_reg} <= 7'h00;
        tsh_reg <= 16'hffff;
        tbusy_reg <= 1'b0;
        tbrk_reg <= 1'b0;
      end else begin
        if (tx_push) begin
          txf_reg[txw_reg] <= bus_wdata[8:0];
          txw_reg <= txw_reg + 2'h1;
        end
        txc_reg <= txc_reg + {2'h0, tx_push} - {2'h0, tx_go};
        if (tx_go) begin
          // Load a frame; a pending break consumes the dummy character
          txr_reg <= txr_reg + 2'h1;
          tbusy_reg <= 1'b1;
          tsc_reg <= 4'h0;
          tbrk_reg <= tx_break_request_reg;
          if (tx_break_request_reg) begin
            tsh_reg <= `UMS_BREAK_FRAME;
            tleft_reg <= `UMS_BREAK_LEN + {3'h0, stop_count_select_reg};
          end else begin
            tsh_reg <= {4'hf, 2'h3, tb8, td[7:0], 1'b0};
            tleft_reg <= tlen;
          end
          // Interrupt on move to shifter, or when it empties the buffer
          if (tx_irq_mode_reg == `UMS_TXI_EACH)
            tx_irq <= 1'b1;
          if ((tx_irq_mode_reg == `UMS_TXI_EMPTY) & (txc_reg == 3'h1) & ~tx_push)
            tx_irq <= 1'b1;
        end else if (tick & tbusy_reg) begin
          // One bit per full count of baud ticks
          if (tsc_reg == full_n) begin
            tsc_reg <= 4'h0;
            tsh_reg <= {1'b1, tsh_reg[15:1]};
            tleft_reg <= tleft_reg - 4'h1;
            if (tleft_reg == 4'h1) begin
              tbusy_reg <= 1'b0;
              if (tbrk_reg & ~(wr_stat & bus_wdata[11]))
                tx_break_request_reg <= 1'b0;
              if ((tx_irq_mode_reg == `UMS_TXI_DONE) & (txc_reg == 3'h0) & ~tx_push)
                tx_irq <= 1'b1;
            end
          end else begin
            tsc_reg <= tsc_reg + 4'h1;
          end
        end
      end
    end
  end

  // Receiver, infrared decoder, receive FIFO and overrun
  always @(posedge clk_sys) begin
    if (!rstn) begin
      {rx_irq_mode_reg, address_detect_on_reg, overrun_error_reg} <= 4'h0;
      {rxw_reg, rxr_reg, rxc_reg} <= 7'h00;
      rst_reg <= RX_IDLE;
      {rsc_reg, rbit_reg} <= 8'h00;
      rsh_reg <= 9'h000;
      ir_cnt_reg <= `UMS_FULL16;
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= 1'b0;
      if (wr_stat) begin
        rx_irq_mode_reg <= bus_wdata[7:6];
        address_detect_on_reg <= bus_wdata[5];
      end
      // Infrared pulse stretches to one bit of low level
      if (~rx_in)
        ir_cnt_reg <= 4'h0;
      else if (tick & (ir_cnt_reg != `UMS_FULL16))
        ir_cnt_reg <= ir_cnt_reg + 4'h1;
      // Overflow sets the flag; set wins over a software clear
      if (r_ovf)
        overrun_error_reg <= 1'b1;
      else if (ovr_clr)
        overrun_error_reg <= 1'b0;
      if (ovr_clr) begin
        // Clearing overrun empties FIFO and shifter
        {rxw_reg, rxr_reg, rxc_reg} <= 7'h00;
      end else begin
        if (r_push) begin
          rxf_reg[rxw_reg] <= {~rx_line, r_par_bad, nine ? rsh_reg[8] : 1'b0, rsh_reg[7:0]};
          rxw_reg <= rxw_reg + 2'h1;
        end
        if (r_pop)
          rxr_reg <= rxr_reg + 2'h1;
        rxc_reg <= rxc_reg + {2'h0, r_push} - {2'h0, r_pop};
        // Fill-level interrupt choice
        if (r_push & ((rx_irq_mode_reg[1] == 1'b0) |
            ((rx_irq_mode_reg == `UMS_RXI_3) & (rxc_reg == 3'h2)) |
            ((rx_irq_mode_reg == `UMS_RXI_4) & (rxc_reg == 3'h3))))
          rx_irq <= 1'b1;
      end
      if (rx_hold) begin
        rst_reg <= RX_IDLE;
      end else begin
        case (rst_reg)
          RX_IDLE: begin
            // Falling edge starts a frame
            if (rx_fall) begin
              rst_reg <= RX_START;
              rsc_reg <= 4'h0;
            end
          end
          RX_START: begin
            // Confirm start bit at its centre
            if (tick) begin
              rsc_reg <= rsc_reg + 4'h1;
              if (rsc_reg == half_n) begin
                rsc_reg <= 4'h0;
                rbit_reg <= 4'h0;
                rst_reg <= rx_line ? RX_IDLE : RX_BITS;
              end
            end
          end
          RX_BITS: begin
            // Data and parity, each one bit later at centre
            if (tick)
              rsc_reg <= rsc_reg + 4'h1;
            if (r_samp) begin
              rsc_reg <= 4'h0;
              rsh_reg[rbit_reg] <= rx_line;
              rbit_reg <= rbit_reg + 4'h1;
              if (rbit_reg == rx_nbits - 4'h1)
                rst_reg <= RX_STOP;
            end
          end
          RX_STOP: begin
            // Stop bit low marks a framing error at push
            if (tick)
              rsc_reg <= rsc_reg + 4'h1;
            if (r_samp)
              rst_reg <= RX_IDLE;
          end
          default: begin
            rst_reg <= RX_IDLE;
          end
        endcase
        if (rx_nbits == 4'h8)
          rsh_reg[8] <= 1'b0;
      end
    end
  end

  // Pin ownership, infrared encoder, RTS and baud clock output
  always @(posedge clk_sys) begin
    if (!rstn) begin
      serial_out_pin <= 1'b1;
      serial_out_oe <= 1'b0;
      request_to_send_pin_n <= 1'b1;
      request_to_send_oe <= 1'b0;
    end else begin
      serial_out_oe <= module_on_reg & tx_on_reg;
      // Infrared: short pulse for each zero bit, idle set by polarity
      if (ir_act)
        serial_out_pin <= (~tx_raw & tbusy_reg & (tsc_reg < `UMS_IR_PULSE)) ^
                          tx_ir_polarity_reg;
      else
        serial_out_pin <= tx_raw;
      request_to_send_oe <= module_on_reg & (pin_usage_select_reg != 2'h0);
      if (pin_usage_select_reg == `UMS_PINS_BCLK)
        request_to_send_pin_n <= bclk_reg;
      else if (rts_pin_mode_reg)
        request_to_send_pin_n <= ~(tbusy_reg | (txc_reg != 3'h0));
      else
        request_to_send_pin_n <= r_full;
    end
  end

  // Register read port, data one cycle after the strobe
  always @(posedge clk_sys) begin
    if (!rstn) begin
      bus_rdata <= 16'h0000;
    end else if (bus_rd) begin
      case (bus_addr)
        `UMS_OFF_MODE: bus_rdata <= {module_on_reg, 1'b0, stop_in_idle_reg,
          infrared_codec_on_reg, rts_pin_mode_reg, 1'b0, pin_usage_select_reg,
          wake_on_start_reg, loopback_select_reg, auto_baud_on_reg,
          rx_polarity_invert_reg, high_baud_select_reg, parity_data_select_reg,
          stop_count_select_reg};
        `UMS_OFF_STAT: bus_rdata <= {tx_irq_mode_reg[1], tx_ir_polarity_reg,
          tx_irq_mode_reg[0], 1'b0, tx_break_request_reg, tx_on_reg,
          txc_reg == `UMS_FIFO_DEPTH, ~tbusy_reg & (txc_reg == 3'h0),
          rx_irq_mode_reg, address_detect_on_reg, rst_reg == RX_IDLE,
          rtop[9] & (rxc_reg != 3'h0), rtop[10] & (rxc_reg != 3'h0),
          overrun_error_reg, rxc_reg != 3'h0};
        `UMS_OFF_RXD: bus_rdata <= (rxc_reg != 3'h0) ? {7'h00, rtop[8:0]} : 16'h0000;
        `UMS_OFF_BRG: bus_rdata <= brg_reg;
        default: bus_rdata <= 16'h0000;
      endcase
    end else begin
      bus_rdata <= 16'h0000;
    end
  end
endmodule

// ==== testbench/ums_top_assertions.sv ====
// Port-level checks for the serial mode/status block
`timescale 1ns/100ps
module ums_top_assertions (
  input wire clk_sys,
  input wire rstn,
  input wire [2:0] bus_addr,
  input wire [15:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [15:0] bus_rdata,
  input wire serial_out_oe,
  input wire request_to_send_oe,
  input wire tx_irq,
  input wire rx_irq,
  input wire wake_irq
);
  reg [2:0] own_reg; // Shadow of module on, tx on, pins in use
  wire tx_own; // Transmit pin should belong to the block
  wire rts_own; // Handshake pin should belong to the block
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // Follow the ownership bits as software writes them
  always @(posedge clk_sys) begin
    if (!rstn) begin
      own_reg <= 3'h0;
    end else if (bus_wr && bus_addr == 3'h0) begin
      own_reg[0] <= bus_wdata[15];
      own_reg[2] <= |bus_wdata[9:8];
    end else if (bus_wr && bus_addr == 3'h1) begin
      own_reg[1] <= bus_wdata[10];
    end
  end
  assign tx_own = own_reg[0] & own_reg[1];
  assign rts_own = own_reg[0] & own_reg[2];
  sequence s_tx_off;
    !tx_own [*3];
  endsequence
  sequence s_tx_on;
    tx_own [*3];
  endsequence
  a_tx_released: assert property (s_tx_off |-> !serial_out_oe)
    else $error("transmit pin kept while disabled");
  a_tx_owned: assert property (s_tx_on |-> serial_out_oe)
    else $error("transmit pin not taken");
  a_rts_released: assert property ((!rts_own) [*3] |-> !request_to_send_oe)
    else $error("handshake pin kept while unused");
  a_rts_owned: assert property (rts_own [*3] |-> request_to_send_oe)
    else $error("handshake pin not taken");
  a_rdata_quiet: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
    else $error("read data outside read answer");
  a_tx_pulse: assert property (tx_irq |=> !tx_irq)
    else $error("transmit interrupt too long");
  a_rx_pulse: assert property (rx_irq |=> !rx_irq)
    else $error("receive interrupt too long");
  a_wake_pulse: assert property (wake_irq |=> !wake_irq)
    else $error("wake interrupt too long");
endmodule
bind ums_top ums_top_assertions i_chk (.clk_sys, .rstn, .bus_addr, .bus_wdata, .bus_wr,
  .bus_rd, .bus_rdata, .serial_out_oe, .request_to_send_oe, .tx_irq, .rx_irq, .wake_irq);

// ==== testbench/ums_partner.sv ====
// Remote serial node driving the receive pin
`timescale 1ns/100ps
module ums_partner (
  input wire clk_sys,
  output reg line_out
);
  initial line_out = 1'b1; // Idle at mark level
  // One 8-bit character, LSB first, chosen stop level and bit length
  task automatic send(input [7:0] data, input stop_bit, input integer clks);
    integer i;
    begin
      line_out <= 1'b0;
      repeat (clks) @(posedge clk_sys);
      for (i = 0; i < 8; i = i + 1) begin
        line_out <= data[i];
        repeat (clks) @(posedge clk_sys);
      end
      line_out <= stop_bit;
      repeat (clks) @(posedge clk_sys);
      line_out <= 1'b1;
      repeat (2 * clks) @(posedge clk_sys);
    end
  endtask
endmodule

// ==== testbench/ums_top_bench.sv ====
// Self-checking bench for the serial mode/status block
`timescale 1ns/100ps
module ums_top_bench;
  reg clk_sys = 1'b0;
  reg rstn = 1'b0;
  reg [2:0] bus_addr = 3'h0;
  reg [15:0] bus_wdata = 16'h0000;
  reg bus_wr = 1'b0;
  reg bus_rd = 1'b0;
  reg cpu_idle = 1'b0; // Device Idle level
  reg cpu_sleep = 1'b0; // Device Sleep level
  wire [15:0] bus_rdata;
  wire rx_line; // Remote node to receive pin
  wire tx_pin;
  wire tx_irq;
  wire rx_irq;
  wire wake_irq;
  wire rts_n; // Request-to-send pin value
  integer fail_count = 0;
  integer compares = 0;
  integer cycles = 0;
  integer irqs = 0; // Interrupt pulses seen
  integer wakes = 0; // Wake pulses seen
  integer i;
  reg [15:0] rv; // Last read value
  reg [15:0] got; // Captured line bits
  always #5 clk_sys = ~clk_sys;
  ums_top i_dut (.clk_sys(clk_sys), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep), .serial_in_pin(rx_line), .clear_to_send_pin_n(1'b1),
    .serial_out_pin(tx_pin), .serial_out_oe(), .request_to_send_pin_n(rts_n),
    .request_to_send_oe(), .tx_irq(tx_irq), .rx_irq(rx_irq), .wake_irq(wake_irq));
  ums_partner i_peer (.clk_sys(clk_sys), .line_out(rx_line));
  // Cycle count, interrupt tally and hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (tx_irq === 1'b1 || rx_irq === 1'b1)
      irqs <= irqs + 1;
    if (wake_irq === 1'b1)
      wakes <= wakes + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      test_done;
    end
  end
  task chk(input string what, input [15:0] exp, input [15:0] seen);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
    end
  endtask
  task wr(input [2:0] a, input [15:0] d);
    begin
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
    end
  endtask
  // Read answer stands only in the cycle after the strobe
  task rd(input [2:0] a);
    begin
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      #1 rv = bus_rdata;
    end
  endtask
  // Catch n bits at bit centres after the next low level; ends at last centre
  task grab(input integer clks, input integer n);
    integer k; // Own counter, callers loop on i
    begin
      got = 16'hffff;
      k = 0;
      while (tx_pin !== 1'b0 && k < 3000) begin
        @(posedge clk_sys);
        #1 k = k + 1;
      end
      repeat (clks / 2) @(posedge clk_sys);
      for (k = 0; k < n; k = k + 1) begin
        #1 got[k] = tx_pin;
        if (k < n - 1)
          repeat (clks) @(posedge clk_sys);
      end
    end
  endtask
  task t_reset;
    begin
      rd(3'h1);
      chk("status reset", 16'h0110, rv);
      rd(3'h7);
      chk("unmapped", 16'h0000, rv);
      wr(3'h0, 16'h7f5f);
      rd(3'h0);
      chk("mode bits", 16'h3b5f, rv);
      $display("t_reset done");
    end
  endtask
  // One character on the line against its expected framing
  task t_frame(input [15:0] mode, input [8:0] d);
    reg [15:0] exp;
    integer clks, base;
    begin
      clks = mode[3] ? 4 : 16;
      exp = 16'hffff;
      exp[8:0] = {d[7:0], 1'b0};
      if (mode[2:1] == 2'h3)
        exp[9] = d[8];
      if (mode[2:1] == 2'h2)
        exp[9] = ~^d[7:0];
      if (mode[2:1] == 2'h1)
        exp[9] = ^d[7:0];
      base = irqs;
      wr(3'h0, mode);
      wr(3'h2, {7'h00, d});
      grab(clks, (mode[2:1] == 2'h0) ? 10 : 11);
      chk("frame", exp, got);
      chk("tx irq", 16'h0001, {15'h0000, irqs > base});
      repeat (clks) @(posedge clk_sys);
      rd(3'h1);
      chk("shifter empty", 16'h0100, rv & 16'h0300);
    end
  endtask
  task t_frames;
    begin
      wr(3'h1, 16'h0400);
      for (i = 0; i < 4; i = i + 1)
        t_frame(16'h8000 | (i << 1), 9'h1a5 ^ i);
      t_frame(16'h8008, 9'h03c);
      $display("t_frames done");
    end
  endtask
  task t_break;
    begin
      wr(3'h0, 16'h8000);
      wr(3'h1, 16'h0c00);
      wr(3'h2, 16'h00ff);
      wr(3'h2, 16'h0055);
      grab(16, 14);
      chk("break", 16'he000, got);
      grab(16, 10);
      chk("sync", 16'hfeaa, got);
      rd(3'h1);
      chk("break clear", 16'h0000, rv & 16'h0800);
      $display("t_break done");
    end
  endtask
  task t_loop;
    begin
      wr(3'h0, 16'h8040);
      wr(3'h2, 16'h003c);
      rv = 16'h0000;
      for (i = 0; i < 150 && rv[0] !== 1'b1; i = i + 1)
        rd(3'h1);
      rd(3'h3);
      chk("loop data", 16'h003c, rv);
      rd(3'h1);
      chk("rx empty", 16'h0000, rv & 16'h0001);
      $display("t_loop done");
    end
  endtask
  // Bad stop on first, fifth overflows, flags follow the FIFO top
  task t_rx;
    integer base;
    begin
      wr(3'h0, 16'h8000);
      wr(3'h1, 16'h0480);
      base = irqs;
      i_peer.send(8'h11, 1'b0, 16);
      i_peer.send(8'h22, 1'b1, 16);
      i_peer.send(8'h33, 1'b1, 16);
      i_peer.send(8'h44, 1'b1, 16);
      i_peer.send(8'h55, 1'b1, 16);
      chk("rx irq", 16'h0001, irqs - base);
      rd(3'h1);
      chk("rx flags", 16'h0017, rv & 16'h001f);
      rd(3'h3);
      chk("rx data", 16'h0011, rv);
      rd(3'h1);
      chk("next flags", 16'h0013, rv & 16'h001f);
      wr(3'h1, 16'h0480);
      rd(3'h1);
      chk("flushed", 16'h0010, rv & 16'h001f);
      $display("t_rx done");
    end
  endtask
  task t_off;
    begin
      wr(3'h1, 16'h0400);
      wr(3'h2, 16'h00f0);
      repeat (40) @(posedge clk_sys);
      wr(3'h1, 16'h0000);
      rd(3'h1);
      chk("tx abort", 16'h0100, rv & 16'h0300);
      $display("t_off done");
    end
  endtask
  task t_ir;
    begin
      wr(3'h0, 16'h9100);
      wr(3'h1, 16'h4400);
      repeat (4) @(posedge clk_sys);
      chk("ir idle 1", 16'h0001, {15'h0000, tx_pin});
      wr(3'h1, 16'h0400);
      repeat (4) @(posedge clk_sys);
      chk("ir idle 0", 16'h0000, {15'h0000, tx_pin});
      wr(3'h0, 16'h9108);
      repeat (4) @(posedge clk_sys);
      chk("ir off fast", 16'h0001, {15'h0000, tx_pin});
      $display("t_ir done");
    end
  endtask
  // Idle halt and resume, simplex request pin, wake on start edge, auto-baud
  task t_misc;
    integer base;
    begin
      wr(3'h0, 16'ha900);
      cpu_idle <= 1'b1;
      wr(3'h2, 16'h0012);
      repeat (20) @(posedge clk_sys);
      #1 chk("idle halt", 16'h0001, {15'h0000, tx_pin});
      chk("rts queued", 16'h0000, {15'h0000, rts_n});
      @(posedge clk_sys);
      cpu_idle <= 1'b0;
      grab(16, 10);
      chk("idle resume", 16'hfe24, got);
      repeat (16) @(posedge clk_sys);
      #1 chk("rts done", 16'h0001, {15'h0000, rts_n});
      wr(3'h0, 16'h8080);
      cpu_sleep <= 1'b1;
      base = wakes;
      i_peer.send(8'h00, 1'b1, 16);
      chk("wake irq", 16'h0001, wakes - base);
      rd(3'h0);
      chk("wake clear", 16'h8000, rv);
      wr(3'h0, 16'h8020);
      cpu_sleep <= 1'b0;
      i_peer.send(8'h55, 1'b1, 32);
      rd(3'h4);
      chk("auto divisor", 16'h0001, rv);
      rd(3'h0);
      chk("auto clear", 16'h8000, rv);
      $display("t_misc done");
    end
  endtask
  task test_done;
    begin
      $display("compares %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset;
    t_frames;
    t_break;
    t_loop;
    t_rx;
    t_off;
    t_ir;
    t_misc;
    test_done;
  end
endmodule
